// >>> rtl/ict_pkg.sv
package ict_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CLK_W = 10;
  localparam int BUS_W = 6;
  localparam int NREG_W = 5;

  typedef logic [CLK_W-1:0] ict_clk_t;
  typedef logic [BUS_W-1:0] ict_bus_t;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction classes, operand sizes, addressing modes, outcomes
  typedef enum logic [4:0] {
    bit_change_op, bit_clear_op, bit_set_op, bit_test_op,
    cond_branch, unconditional_branch, branch_to_subroutine,
    decrement_and_branch, jump_op, jump_to_subroutine,
    load_effective_address, push_effective_address,
    multi_register_move, alternate_space_move,
    extended_add, extended_subtract, memory_compare,
    decimal_add, decimal_subtract
  } ict_op_e;

  typedef enum logic [1:0] {size_byte, size_word, size_long} ict_size_e;

  typedef enum logic [3:0] {
    mode_reg, mode_ind, mode_postinc, mode_predec, mode_d16, mode_index,
    mode_abs_w, mode_abs_l, mode_pc_d16, mode_pc_index
  } ict_mode_e;

  typedef enum logic [2:0] {
    out_taken, out_not_taken, out_loop_continue, out_loop_true,
    out_loop_expired
  } ict_outcome_e;

  typedef enum logic [1:0] {step_none, step_postinc, step_predec} ict_step_e;

  ////////////////////////////////////////////////////////////////////////////
  // Cost triple: valid, clock periods, read cycles, write cycles
  typedef struct packed {
    logic ok;
    logic [7:0] clk;
    logic [3:0] rd;
    logic [3:0] wr;
  } ict_cost_s;

  // Packed as clocks in bits 15:8, reads in 7:4, writes in 3:0
  function automatic ict_cost_s cost(input logic [15:0] v);
    cost = '{1'b1, v[15:8], v[7:4], v[3:0]};
  endfunction : cost

  localparam ict_cost_s NA_COST = '{1'b0, 8'h00, 4'h0, 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Bit manipulation: change, clear, set, test
  localparam ict_cost_s BIT_DYN_REG [4] =
    '{cost(16'h0810), cost(16'h0a10), cost(16'h0810), cost(16'h0610)};
  localparam ict_cost_s BIT_DYN_MEM [4] =
    '{cost(16'h0811), cost(16'h0a11), cost(16'h0811), cost(16'h0410)};
  localparam ict_cost_s BIT_IMM_EXTRA = cost(16'h0410);

  ////////////////////////////////////////////////////////////////////////////
  // Branches
  localparam ict_cost_s BCC_TAKEN = cost(16'h0a20);
  localparam ict_cost_s BCC_NT_BYTE = cost(16'h0610);
  localparam ict_cost_s BCC_NT_WORD = cost(16'h0a20);
  localparam ict_cost_s BRA_COST = cost(16'h0a20);
  localparam ict_cost_s BSR_COST = cost(16'h1222);
  localparam ict_cost_s DECREMENT_AND_BRANCH_RUN = cost(16'h0a20);
  localparam ict_cost_s DECREMENT_AND_BRANCH_EXPIRED = cost(16'h1030);

  ////////////////////////////////////////////////////////////////////////////
  // Per addressing mode, indexed by ict_mode_e
  localparam ict_cost_s JMP_COST [10] = '{NA_COST, cost(16'h0820), NA_COST,
    NA_COST, cost(16'h0a20), cost(16'h0e30), cost(16'h0a20), cost(16'h0c30),
    cost(16'h0a20), cost(16'h0e30)};
  localparam ict_cost_s JSR_COST [10] = '{NA_COST, cost(16'h1022), NA_COST,
    NA_COST, cost(16'h1222), cost(16'h1622), cost(16'h1222), cost(16'h1432),
    cost(16'h1222), cost(16'h1622)};
  localparam ict_cost_s LEA_COST [10] = '{NA_COST, cost(16'h0410), NA_COST,
    NA_COST, cost(16'h0820), cost(16'h0c20), cost(16'h0820), cost(16'h0c30),
    cost(16'h0820), cost(16'h0c20)};
  localparam ict_cost_s PEA_COST [10] = '{NA_COST, cost(16'h0c12), NA_COST,
    NA_COST, cost(16'h1022), cost(16'h1422), cost(16'h1022), cost(16'h1432),
    cost(16'h1022), cost(16'h1422)};
  localparam ict_cost_s MR_W_COST [10] = '{NA_COST, cost(16'h0c30),
    cost(16'h0c30), NA_COST, cost(16'h1040), cost(16'h1240), cost(16'h1040),
    cost(16'h1450), cost(16'h1040), cost(16'h1240)};
  localparam ict_cost_s MR_L_COST [10] = '{NA_COST, cost(16'h1830),
    cost(16'h0c30), NA_COST, cost(16'h1040), cost(16'h1240), cost(16'h1040),
    cost(16'h1450), cost(16'h1040), cost(16'h1240)};
  localparam ict_cost_s RM_COST [10] = '{NA_COST, cost(16'h0820), NA_COST,
    cost(16'h0820), cost(16'h0c30), cost(16'h0e30), cost(16'h0c30),
    cost(16'h1040), NA_COST, NA_COST};
  localparam ict_cost_s SMR_BW_COST [10] = '{NA_COST, cost(16'h1230),
    cost(16'h1430), cost(16'h1430), cost(16'h1440), cost(16'h1840),
    cost(16'h1440), cost(16'h1850), NA_COST, NA_COST};
  localparam ict_cost_s SMR_L_COST [10] = '{NA_COST, cost(16'h1640),
    cost(16'h1840), cost(16'h1840), cost(16'h1850), cost(16'h1c50),
    cost(16'h1850), cost(16'h1c60), NA_COST, NA_COST};
  localparam ict_cost_s SRM_BW_COST [10] = '{NA_COST, cost(16'h1221),
    cost(16'h1421), cost(16'h1421), cost(16'h1431), cost(16'h1831),
    cost(16'h1431), cost(16'h1841), NA_COST, NA_COST};
  localparam ict_cost_s SRM_L_COST [10] = '{NA_COST, cost(16'h1622),
    cost(16'h1822), cost(16'h1822), cost(16'h1832), cost(16'h1c32),
    cost(16'h1832), cost(16'h1c42), NA_COST, NA_COST};

  // Register multiple step per register moved, word and long
  localparam ict_clk_t MULTI_REGISTER_MOVE_STEP_CLK_W = 10'h004;
  localparam ict_clk_t MULTI_REGISTER_MOVE_STEP_CLK_L = 10'h008;
  localparam ict_bus_t MULTI_REGISTER_MOVE_STEP_BUS_W = 6'h01;
  localparam ict_bus_t MULTI_REGISTER_MOVE_STEP_BUS_L = 6'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Multiprecision: register, memory, loop continue, loop true, expired
  localparam ict_cost_s XADD_BW [5] = '{cost(16'h0410), cost(16'h1231),
    cost(16'h1621), cost(16'h1c41), cost(16'h1a41)};
  localparam ict_cost_s XADD_L [5] = '{cost(16'h0610), cost(16'h1e52),
    cost(16'h2042), cost(16'h2662), cost(16'h2462)};
  localparam ict_cost_s MEMORY_COMPARE_BW [5] = '{NA_COST, cost(16'h0c30),
    cost(16'h0e20), cost(16'h1440), cost(16'h1240)};
  localparam ict_cost_s MEMORY_COMPARE_L [5] = '{NA_COST, cost(16'h1450),
    cost(16'h1840), cost(16'h1e60), cost(16'h1a60)};
  localparam ict_cost_s DEC_B [5] = '{cost(16'h0610), cost(16'h1231),
    cost(16'h1821), cost(16'h1e41), cost(16'h1c41)};

endpackage : ict_pkg

// >>> rtl/ict_ea_adder.sv
`timescale 1ns/10ps
module ict_ea_adder (
  input wire logic i_add,
  input wire ict_pkg::ict_clk_t i_base_clk,
  input wire ict_pkg::ict_bus_t i_base_rd,
  input wire ict_pkg::ict_bus_t i_base_wr,
  input wire logic [7:0] i_ea_clk,
  input wire logic [3:0] i_ea_rd,
  input wire logic [3:0] i_ea_wr,
  output logic [ict_pkg::CLK_W-1:0] o_clk,
  output logic [ict_pkg::BUS_W-1:0] o_rd,
  output logic [ict_pkg::BUS_W-1:0] o_wr
);

  // Index size has no input here, so it cannot change the cost
  always_comb begin
    o_clk = i_base_clk;
    o_rd = i_base_rd;
    o_wr = i_base_wr;
    if (i_add) begin
      o_clk = i_base_clk + {2'h0, i_ea_clk};
      o_rd = i_base_rd + {2'h0, i_ea_rd};
      o_wr = i_base_wr + {2'h0, i_ea_wr};
    end
  end

endmodule : ict_ea_adder

// >>> rtl/ict_clock_counter.sv
`timescale 1ns/10ps
module ict_clock_counter (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire ict_pkg::ict_clk_t i_count,
  input wire logic i_stall,
  output logic o_finish,
  output logic [ict_pkg::CLK_W-1:0] o_stalls
);

  ict_pkg::ict_clk_t cnt_ff, nxt_cnt, stalls_ff, nxt_stalls;
  logic active_ff, nxt_active, finish_ff, nxt_finish;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_stalls = stalls_ff;
    nxt_active = active_ff;
    nxt_finish = 1'b0;
    if (i_load) begin
      nxt_cnt = i_count;
      nxt_stalls = '0;
      nxt_active = 1'b1;
    end else if (active_ff) begin
      if (i_stall) begin
        nxt_stalls = stalls_ff + 10'h001;
      end else if (cnt_ff <= 10'h001) begin
        nxt_active = 1'b0;
        nxt_finish = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 10'h001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
      stalls_ff <= '0;
      active_ff <= 1'b0;
      finish_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      stalls_ff <= nxt_stalls;
      active_ff <= nxt_active;
      finish_ff <= nxt_finish;
    end
  end

  assign o_finish = finish_ff;
  assign o_stalls = stalls_ff;

endmodule : ict_clock_counter

// >>> rtl/ict_timing.sv
// Overview of operation
// - Every instruction is costed as clocks, read cycles and write cycles.
// - Flagged entries add the address calculation triple to the base.
// - Memory bit ops 8(1/1), clear 10, test 4(1/0); immediate adds 4(1/0).
// - Register bit ops 8, 10 or 6 (1/0); immediate forms add 4(1/0).
// - Branch taken 10(2/0); not taken 6(1/0) byte, 10(2/0) word.
// - Unconditional branch 10(2/0); subroutine branch 18(2/2), any size.
// - Decrement loop 10(2/0) on true or loop back; expired 16(3/0).
// - Indirect jump 8, subroutine jump 16, load 4, push 12 clocks.
// - Multi register alternate_space_move grow with n by 4 or 8 clocks per register.
// - Alternate space indirect alternate_space_move take 18 or 22 clocks.
// - Index register size never changes the cost.
// - Multiprecision figures are complete; no address cost is added.
// - Extended add/subtract 4/6 register, 18/30 memory; decimal 6/18.
// - Memory compare is memory only: 12(3/0) or 20(5/0).
// - Compare uses postincrement; add, subtract, decimal use predecrement in memory mode.
// - Loop mode costs per outcome, e.g. 22, 28, 26 and 14, 20, 18.
`timescale 1ns/10ps
module ict_timing (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire ict_pkg::ict_op_e i_op,
  input wire ict_pkg::ict_size_e i_size,
  input wire ict_pkg::ict_mode_e i_mode,
  input wire ict_pkg::ict_outcome_e i_outcome,
  input wire logic i_static_bit,
  input wire logic i_to_memory,
  input wire logic i_loop,
  input wire logic [ict_pkg::NREG_W-1:0] i_reg_count,
  input wire logic [7:0] i_ea_clocks,
  input wire logic [3:0] i_ea_reads,
  input wire logic [3:0] i_ea_writes,
  input wire logic i_bus_wait,
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  output logic [ict_pkg::CLK_W-1:0] o_clocks,
  output logic [ict_pkg::BUS_W-1:0] o_reads,
  output logic [ict_pkg::BUS_W-1:0] o_writes,
  output logic [ict_pkg::CLK_W-1:0] o_wait_clocks,
  output ict_pkg::ict_step_e o_addr_step
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic {st_idle, st_run} ict_state_e;

  ict_state_e state_ff, nxt_state;
  ict_pkg::ict_cost_s base;
  ict_pkg::ict_clk_t step_clk, tot_clk, sum_clk;
  ict_pkg::ict_bus_t step_rd, step_wr, tot_rd, tot_wr, sum_rd, sum_wr;
  ict_pkg::ict_step_e step;
  logic plus;
  logic [1:0] bit_idx;
  logic [2:0] mp_idx;
  logic mp_ok;
  logic busy_ff, nxt_busy, done_ff, nxt_done, error_ff, nxt_error;
  ict_pkg::ict_clk_t clocks_ff, nxt_clocks, waits_ff, nxt_waits;
  ict_pkg::ict_bus_t reads_ff, nxt_reads, writes_ff, nxt_writes;
  ict_pkg::ict_step_e step_ff, nxt_step;
  logic cnt_load, cnt_finish;
  ict_pkg::ict_clk_t cnt_stalls;

  ////////////////////////////////////////////////////////////////////////////
  // Bit operation and multiprecision row selects
  always_comb begin
    case (i_op)
      ict_pkg::bit_change_op: bit_idx = 2'h0;
      ict_pkg::bit_clear_op: bit_idx = 2'h1;
      ict_pkg::bit_set_op: bit_idx = 2'h2;
      default: bit_idx = 2'h3;
    endcase
  end

  always_comb begin
    mp_ok = 1'b1;
    if (i_mode == ict_pkg::mode_reg) begin
      mp_idx = 3'h0;
    end else if (!i_loop) begin
      mp_idx = 3'h1;
    end else begin
      case (i_outcome)
        ict_pkg::out_loop_continue: mp_idx = 3'h2;
        ict_pkg::out_loop_true: mp_idx = 3'h3;
        ict_pkg::out_loop_expired: mp_idx = 3'h4;
        default: begin
          mp_idx = 3'h0;
          mp_ok = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base cost lookup
  always_comb begin
    base = ict_pkg::NA_COST;
    step_clk = '0;
    step_rd = '0;
    step_wr = '0;
    plus = 1'b0;
    step = ict_pkg::step_none;
    case (i_op)
      ict_pkg::bit_change_op, ict_pkg::bit_clear_op,
      ict_pkg::bit_set_op, ict_pkg::bit_test_op: begin
        if (i_mode == ict_pkg::mode_reg) begin
          if (i_size == ict_pkg::size_long) begin
            base = ict_pkg::BIT_DYN_REG[bit_idx];
          end
        end else if (i_size == ict_pkg::size_byte) begin
          base = ict_pkg::BIT_DYN_MEM[bit_idx];
          plus = 1'b1;
        end
        if (i_static_bit && base.ok) begin
          base.clk = base.clk + ict_pkg::BIT_IMM_EXTRA.clk;
          base.rd = base.rd + ict_pkg::BIT_IMM_EXTRA.rd;
        end
      end
      ict_pkg::cond_branch: begin
        if (i_outcome == ict_pkg::out_taken) begin
          base = ict_pkg::BCC_TAKEN;
        end else if (i_outcome == ict_pkg::out_not_taken) begin
          if (i_size == ict_pkg::size_byte) begin
            base = ict_pkg::BCC_NT_BYTE;
          end else begin
            base = ict_pkg::BCC_NT_WORD;
          end
        end
      end
      ict_pkg::unconditional_branch: begin
        base = ict_pkg::BRA_COST;
      end
      ict_pkg::branch_to_subroutine: begin
        base = ict_pkg::BSR_COST;
      end
      ict_pkg::decrement_and_branch: begin
        case (i_outcome)
          ict_pkg::out_not_taken, ict_pkg::out_taken: begin
            base = ict_pkg::DECREMENT_AND_BRANCH_RUN;
          end
          ict_pkg::out_loop_expired: begin
            base = ict_pkg::DECREMENT_AND_BRANCH_EXPIRED;
          end
          default: begin
            base = ict_pkg::NA_COST;
          end
        endcase
      end
      ict_pkg::jump_op: begin
        base = ict_pkg::JMP_COST[i_mode];
      end
      ict_pkg::jump_to_subroutine: begin
        base = ict_pkg::JSR_COST[i_mode];
      end
      ict_pkg::load_effective_address: begin
        base = ict_pkg::LEA_COST[i_mode];
      end
      ict_pkg::push_effective_address: begin
        base = ict_pkg::PEA_COST[i_mode];
      end
      ict_pkg::multi_register_move: begin
        if (i_size == ict_pkg::size_long) begin
          step_clk = ict_pkg::MULTI_REGISTER_MOVE_STEP_CLK_L;
        end else begin
          step_clk = ict_pkg::MULTI_REGISTER_MOVE_STEP_CLK_W;
        end
        if (i_to_memory) begin
          base = ict_pkg::RM_COST[i_mode];
          if (i_size == ict_pkg::size_long) begin
            step_wr = ict_pkg::MULTI_REGISTER_MOVE_STEP_BUS_L;
          end else begin
            step_wr = ict_pkg::MULTI_REGISTER_MOVE_STEP_BUS_W;
          end
        end else begin
          if (i_size == ict_pkg::size_long) begin
            base = ict_pkg::MR_L_COST[i_mode];
            step_rd = ict_pkg::MULTI_REGISTER_MOVE_STEP_BUS_L;
          end else begin
            base = ict_pkg::MR_W_COST[i_mode];
            step_rd = ict_pkg::MULTI_REGISTER_MOVE_STEP_BUS_W;
          end
        end
        if (i_size == ict_pkg::size_byte) begin
          base = ict_pkg::NA_COST;
        end
      end
      ict_pkg::alternate_space_move: begin
        if (i_to_memory) begin
          if (i_size == ict_pkg::size_long) begin
            base = ict_pkg::SRM_L_COST[i_mode];
          end else begin
            base = ict_pkg::SRM_BW_COST[i_mode];
          end
        end else begin
          if (i_size == ict_pkg::size_long) begin
            base = ict_pkg::SMR_L_COST[i_mode];
          end else begin
            base = ict_pkg::SMR_BW_COST[i_mode];
          end
        end
      end
      ict_pkg::extended_add, ict_pkg::extended_subtract: begin
        if (i_size == ict_pkg::size_long) begin
          base = ict_pkg::XADD_L[mp_idx];
        end else begin
          base = ict_pkg::XADD_BW[mp_idx];
        end
        if (i_mode != ict_pkg::mode_reg) begin
          step = ict_pkg::step_predec;
        end
      end
      ict_pkg::memory_compare: begin
        if (i_size == ict_pkg::size_long) begin
          base = ict_pkg::MEMORY_COMPARE_L[mp_idx];
        end else begin
          base = ict_pkg::MEMORY_COMPARE_BW[mp_idx];
        end
        step = ict_pkg::step_postinc;
      end
      ict_pkg::decimal_add, ict_pkg::decimal_subtract: begin
        if (i_size == ict_pkg::size_byte) begin
          base = ict_pkg::DEC_B[mp_idx];
        end
        if (i_mode != ict_pkg::mode_reg) begin
          step = ict_pkg::step_predec;
        end
      end
      default: begin
        base = ict_pkg::NA_COST;
      end
    endcase
    if (i_op >= ict_pkg::extended_add && !mp_ok) begin
      base = ict_pkg::NA_COST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scale by register count, then add address calculation when flagged
  always_comb begin
    tot_clk = {2'h0, base.clk}
      + ict_pkg::ict_clk_t'(i_reg_count) * step_clk;
    tot_rd = {2'h0, base.rd}
      + ict_pkg::ict_bus_t'(i_reg_count) * step_rd;
    tot_wr = {2'h0, base.wr}
      + ict_pkg::ict_bus_t'(i_reg_count) * step_wr;
  end

  ict_ea_adder u_ea_adder (
    .i_add(plus),
    .i_base_clk(tot_clk),
    .i_base_rd(tot_rd),
    .i_base_wr(tot_wr),
    .i_ea_clk(i_ea_clocks),
    .i_ea_rd(i_ea_reads),
    .i_ea_wr(i_ea_writes),
    .o_clk(sum_clk),
    .o_rd(sum_rd),
    .o_wr(sum_wr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Execution clock counter with bus wait stretching
  assign cnt_load = (state_ff == st_idle) && i_start && base.ok;

  ict_clock_counter u_counter (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(cnt_load),
    .i_count(sum_clk),
    .i_stall(i_bus_wait),
    .o_finish(cnt_finish),
    .o_stalls(cnt_stalls)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control
  always_comb begin
    nxt_state = state_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_error = 1'b0;
    nxt_clocks = clocks_ff;
    nxt_reads = reads_ff;
    nxt_writes = writes_ff;
    nxt_waits = waits_ff;
    nxt_step = step_ff;
    case (state_ff)
      st_idle: begin
        if (i_start) begin
          if (base.ok) begin
            nxt_state = st_run;
            nxt_busy = 1'b1;
            nxt_clocks = sum_clk;
            nxt_reads = sum_rd;
            nxt_writes = sum_wr;
            nxt_waits = '0;
            nxt_step = step;
          end else begin
            nxt_error = 1'b1;
          end
        end
      end
      st_run: begin
        if (cnt_finish) begin
          nxt_state = st_idle;
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
          nxt_waits = cnt_stalls;
        end
      end
      default: begin
        nxt_state = st_idle;
        nxt_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= st_idle;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      error_ff <= 1'b0;
      clocks_ff <= '0;
      reads_ff <= '0;
      writes_ff <= '0;
      waits_ff <= '0;
      step_ff <= ict_pkg::step_none;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      error_ff <= nxt_error;
      clocks_ff <= nxt_clocks;
      reads_ff <= nxt_reads;
      writes_ff <= nxt_writes;
      waits_ff <= nxt_waits;
      step_ff <= nxt_step;
    end
  end

  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_error = error_ff;
  assign o_clocks = clocks_ff;
  assign o_reads = reads_ff;
  assign o_writes = writes_ff;
  assign o_wait_clocks = waits_ff;
  assign o_addr_step = step_ff;

endmodule : ict_timing

// >>> verification/ict_bus_model.sv
`timescale 1ns/10ps
module ict_bus_model #(
  parameter int LEN = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_busy,
  input wire logic i_en,
  output logic o_wait
);
  logic [3:0] cnt_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= !i_busy ? 4'h0 : cnt_ff == 4'hf ? cnt_ff : cnt_ff + 4'h1;
    end
  end
  // Slow memory stretches the early cycles of an execution
  assign o_wait = i_en && i_busy && cnt_ff != 4'h0 && cnt_ff <= LEN;
endmodule : ict_bus_model

// >>> verification/ict_timing_assertions.sv
`timescale 1ns/10ps
module ict_timing_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire ict_pkg::ict_op_e i_op,
  input wire ict_pkg::ict_mode_e i_mode,
  input wire ict_pkg::ict_outcome_e i_outcome,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_error,
  input wire logic [9:0] o_clocks,
  input wire logic [5:0] o_reads,
  input wire logic [5:0] o_writes,
  input wire logic [9:0] o_wait_clocks,
  input wire ict_pkg::ict_step_e o_addr_step
);
  logic [10:0] cnt_ff;
  logic take;
  assign take = i_start && !o_busy;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 11'h000;
    end else begin
      cnt_ff <= o_busy ? cnt_ff + 11'h001 : 11'h000;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_take_answer: assert property (take |=> o_busy != o_error)
    else $error("request not answered");
  chk_done_span: assert property (o_done |->
    cnt_ff == o_clocks + o_wait_clocks + 11'h001) else $error("bad span");
  chk_done_pulse: assert property (o_done |->
    $fell(o_busy) ##1 !o_done) else $error("bad done pulse");
  chk_branch_cost: assert property (take &&
    i_op == ict_pkg::unconditional_branch |=> o_clocks == 10'h00a &&
    o_reads == 6'h02 && o_writes == 6'h00) else $error("branch cost");
  chk_subr_cost: assert property (take &&
    i_op == ict_pkg::branch_to_subroutine |=> o_clocks == 10'h012 &&
    o_reads == 6'h02 && o_writes == 6'h02) else $error("subroutine cost");
  chk_loop_expired: assert property (take &&
    i_op == ict_pkg::decrement_and_branch &&
    i_outcome == ict_pkg::out_loop_expired |=> o_clocks == 10'h010 &&
    o_reads == 6'h03 && o_writes == 6'h00) else $error("expired cost");
  chk_compare_step: assert property (take &&
    i_op == ict_pkg::memory_compare |=> o_error ||
    o_addr_step == ict_pkg::step_postinc) else $error("compare step");
  chk_sub_step: assert property (take &&
    i_op == ict_pkg::extended_subtract && i_mode != ict_pkg::mode_reg |=>
    o_error || o_addr_step == ict_pkg::step_predec) else $error("sub step");
endmodule : ict_timing_assertions

bind ict_timing ict_timing_assertions u_chk (
  .i_clk, .i_rst_n, .i_start, .i_op, .i_mode, .i_outcome, .o_busy, .o_done,
  .o_error, .o_clocks, .o_reads, .o_writes, .o_wait_clocks, .o_addr_step
);

// >>> verification/ict_timing_tb.sv
`timescale 1ns/10ps
module ict_timing_tb;
  logic i_clk, i_rst_n, i_start, i_static_bit, i_to_memory, i_loop;
  ict_pkg::ict_op_e i_op;
  ict_pkg::ict_size_e i_size;
  ict_pkg::ict_mode_e i_mode;
  ict_pkg::ict_outcome_e i_outcome;
  logic [4:0] i_reg_count;
  logic [7:0] i_ea_clocks;
  logic [3:0] i_ea_reads, i_ea_writes;
  logic i_bus_wait, o_busy, o_done, o_error, slow;
  logic [9:0] o_clocks, o_wait_clocks;
  logic [5:0] o_reads, o_writes;
  ict_pkg::ict_step_e o_addr_step;
  int failures = 0, checked = 0, wait_exp = 0;
  ict_timing DUT (
    .i_clk, .i_rst_n, .i_start, .i_op, .i_size, .i_mode, .i_outcome,
    .i_static_bit, .i_to_memory, .i_loop, .i_reg_count, .i_ea_clocks,
    .i_ea_reads, .i_ea_writes, .i_bus_wait, .o_busy, .o_done, .o_error,
    .o_clocks, .o_reads, .o_writes, .o_wait_clocks, .o_addr_step
  );
  ict_bus_model #(.LEN(3)) u_bus (.i_clk, .i_rst_n, .i_busy(o_busy),
    .i_en(slow), .o_wait(i_bus_wait));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [9:0] seen, input int e);
    checked++;
    if (seen !== e) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", nm, e, seen);
    end
  endtask : check
  // Issue one request; c of zero means a refusal is expected
  task automatic go(input int op, sz, md, oc, x, c, r, w);
    int n;
    @(posedge i_clk);
    i_op <= ict_pkg::ict_op_e'(op);
    i_size <= ict_pkg::ict_size_e'(sz);
    i_mode <= ict_pkg::ict_mode_e'(md);
    i_outcome <= ict_pkg::ict_outcome_e'(oc);
    {i_static_bit, i_to_memory, i_loop, i_reg_count, i_ea_clocks, i_ea_reads,
      i_ea_writes} <= x[23:0];
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    check("busy", {9'h000, o_busy}, c != 0);
    n = 0;
    while (o_done !== 1'b1 && o_error !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("error", {9'h000, o_error}, c == 0);
    if (c != 0) begin
      check("clocks", o_clocks, c);
      check("reads", {4'h0, o_reads}, r);
      check("writes", {4'h0, o_writes}, w);
      check("span", n[9:0], c + wait_exp + 1);
      check("waits", o_wait_clocks, wait_exp);
    end
  endtask : go
  task automatic t_bits;
    int mc[4] = '{8, 10, 8, 4};
    int rc[4] = '{8, 10, 8, 6};
    for (int k = 0; k < 4; k++) begin
      go(k, 0, 1, 0, 'h0321, mc[k] + 3, 3, (k < 3) + 1);
      go(k, 0, 1, 0, 'h800000, mc[k] + 4, 2, k < 3);
      go(k, 2, 0, 0, 'h0321, rc[k], 1, 0);
      go(k, 2, 0, 0, 'h800000, rc[k] + 4, 2, 0);
    end
    go(0, 0, 0, 0, 0, 0, 0, 0);
    $display("bit operations done");
  endtask : t_bits
  task automatic t_branch;
    for (int s = 0; s < 2; s++) begin
      go(4, s, 0, 0, 0, 10, 2, 0);
      go(4, s, 0, 1, 0, s ? 10 : 6, s + 1, 0);
      go(5, s, 0, 0, 0, 10, 2, 0);
      go(6, s, 0, 0, 0, 18, 2, 2);
    end
    go(7, 1, 0, 1, 0, 10, 2, 0);
    go(7, 1, 0, 0, 0, 10, 2, 0);
    go(7, 1, 0, 4, 0, 16, 3, 0);
    go(7, 1, 0, 3, 0, 0, 0, 0);
    $display("branches done");
  endtask : t_branch
  task automatic t_ea;
    int c[4] = '{8, 16, 4, 12};
    int r[4] = '{2, 2, 1, 1};
    int w[4] = '{0, 2, 0, 2};
    for (int k = 0; k < 4; k++) begin
      go(8 + k, 2, 1, 0, 0, c[k], r[k], w[k]);
      go(8 + k, 2, 0, 0, 0, 0, 0, 0);
    end
    go(8, 2, 7, 0, 0, 12, 3, 0);
    go(9, 2, 5, 0, 0, 22, 2, 2);
    go(11, 2, 9, 0, 0, 20, 2, 2);
    go(12, 2, 1, 0, 2 << 16, 40, 7, 0);
    $display("address operations done");
  endtask : t_ea
  task automatic t_move;
    for (int n = 0; n < 32; n += 31) begin
      go(12, 1, 1, 0, n << 16, 12 + 4 * n, 3 + n, 0);
      go(12, 1, 1, 0, 'h400000 | n << 16, 8 + 4 * n, 2, n);
      go(12, 2, 1, 0, 'h400000 | n << 16, 8 + 8 * n, 2, 2 * n);
    end
    go(13, 0, 1, 0, 0, 18, 3, 0);
    go(13, 2, 1, 0, 0, 22, 4, 0);
    go(13, 1, 1, 0, 'h400000, 18, 2, 1);
    go(13, 2, 1, 0, 'h400000, 22, 2, 2);
    $display("register alternate_space_move done");
  endtask : t_move
  task automatic t_mp;
    for (int op = 14; op < 16; op++) begin
      go(op, 0, 0, 0, 0, 4, 1, 0);
      go(op, 2, 0, 0, 0, 6, 1, 0);
      go(op, 2, 3, 0, 0, 30, 5, 2);
      go(op, 1, 3, 0, 0, 18, 3, 1);
      check("step", {8'h00, o_addr_step}, int'(ict_pkg::step_predec));
      go(op, 0, 3, 2, 'h200000, 22, 2, 1);
      go(op, 0, 3, 3, 'h200000, 28, 4, 1);
      go(op, 0, 3, 4, 'h200000, 26, 4, 1);
      go(op + 3, 0, 0, 0, 0, 6, 1, 0);
      go(op + 3, 0, 3, 0, 0, 18, 3, 1);
    end
    go(16, 2, 2, 0, 0, 20, 5, 0);
    go(16, 1, 2, 0, 0, 12, 3, 0);
    check("step", {8'h00, o_addr_step}, int'(ict_pkg::step_postinc));
    go(16, 0, 0, 0, 0, 0, 0, 0);
    go(16, 0, 2, 2, 'h200000, 14, 2, 0);
    go(16, 0, 2, 3, 'h200000, 20, 4, 0);
    go(16, 0, 2, 4, 'h200000, 18, 4, 0);
    $display("multiprecision done");
  endtask : t_mp
  task automatic t_wait;
    @(posedge i_clk);
    slow <= 1'b1;
    wait_exp = 3;
    go(3, 2, 0, 0, 0, 6, 1, 0);
    @(posedge i_clk);
    slow <= 1'b0;
    wait_exp = 0;
    go(5, 0, 0, 0, 0, 10, 2, 0);
    $display("bus waits done");
  endtask : t_wait
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  initial begin
    #400000;
    failures++;
    summarize();
  end
  initial begin
    i_rst_n = 1'b0;
    i_start = 1'b0;
    slow = 1'b0;
    i_op = ict_pkg::bit_change_op;
    i_size = ict_pkg::size_byte;
    i_mode = ict_pkg::mode_reg;
    i_outcome = ict_pkg::out_taken;
    {i_static_bit, i_to_memory, i_loop, i_reg_count, i_ea_clocks, i_ea_reads,
      i_ea_writes} = '0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    check("clocks", o_clocks, 0);
    t_bits();
    t_branch();
    t_ea();
    t_move();
    t_mp();
    t_wait();
    summarize();
  end
endmodule : ict_timing_tb
